// ==== rtl/eight_bit_timer_counter.sv ====
// 8-bit timer/counter with shared prescaler, AHB-Lite register slave
`timescale 1ns/10ps
// Behaviour
// [RULE1] clock_source_select clear: count advances once per instruction cycle without prescaler.
// [RULE2] after a count write, counting pauses two instruction cycles, then resumes.
// [RULE3] clock_source_select set: count advances on chosen external_count_input edge.
// [RULE4] source_edge_select clear picks rising edges, set picks falling edges.
// [RULE5] overflow_flag sets when count wraps from FFh to 00h.
// [RULE6] overflow interrupt requested only while overflow_int_enable (bit 5) is set.
// [RULE7] overflow_flag (bit 2) stays set until software clears it.
// [RULE8] timer stops during sleep, so overflow never wakes the processor.
// [RULE9] with no prescaler, external input passes straight to the synchroniser.
// [RULE10] external path sampled on phase_two and phase_four of each cycle.
// [RULE11] one 8-bit prescaler, shared by timer and watchdog.
// [RULE12] prescaler_assign set gives prescaler to watchdog, clear gives it to timer.
// [RULE13] prescale_rate 000..111 gives timer 1:2..1:256, watchdog 1:1..1:128.
// [RULE14] count_register reads current count; writing loads the written value.
module eight_bit_timer_counter (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // pins and system
  input wire logic external_count_input_i,
  input wire logic sleep_i,
  input wire logic wdt_tick_i,
  output logic wdt_tick_o,
  output logic irq_o
);
  import timer_counter_pkg::*;

  // ==========================================================================
  // state
  phase_t phase_r, phase_nxt;
  ahb_req_t req_r, req_nxt;
  option_t option_r, option_nxt;
  logic [7:0] count_r, count_nxt;
  logic [7:0] presc_r, presc_nxt;
  logic [1:0] hold_r, hold_nxt;
  logic flag_r, flag_nxt;
  logic ovf_en_r, ovf_en_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic sync1_r, sync2_r, sync3_r;
  logic ext_lvl_r, ext_lvl_nxt;
  logic edge_prev_r, edge_prev_nxt;
  logic samp_r, samp_nxt;
  logic samp_prev_r, samp_prev_nxt;
  logic wdt_out_r, wdt_out_nxt;

  // ==========================================================================
  // combinational helpers
  logic addr_ok;
  logic wr_cycle;
  logic wr_count, wr_option, wr_intctl, wr_clear, wr_enable;
  logic cycle_tick;
  logic sample_tick;
  logic ext_rise;
  logic ext_fall;
  logic samp_rise;
  logic samp_fall;
  logic ext_edge;
  logic to_timer;
  logic [7:0] rate_mask;
  logic [7:0] wdt_mask;
  logic presc_full;
  logic presc_step;
  logic presc_bit;
  logic feed_lvl;
  logic inc;
  logic ovf;
  logic [7:0] wdata8;

  assign addr_ok = hsel_i && htrans_i[1] && hready_i;
  assign wr_cycle = req_r.sel && req_r.wr;
  assign wdata8 = hwdata_i[7:0];
  assign wr_count = wr_cycle && (req_r.addr == OFF_COUNT);
  assign wr_option = wr_cycle && (req_r.addr == OFF_OPTION);
  assign wr_intctl = wr_cycle && (req_r.addr == OFF_INTCTL);
  assign wr_clear = wr_cycle && (req_r.addr == OFF_CLEAR);
  assign wr_enable = wr_cycle && (req_r.addr == OFF_ENABLE);

  // one clock per internal phase; four phases make one instruction cycle
  assign cycle_tick = (phase_r == PH_FOUR);
  assign sample_tick = (phase_r == PH_TWO) || (phase_r == PH_FOUR); // [RULE10]

  // edge choice sits after the detectors, so flipping the select bit alone counts nothing
  assign ext_rise = ext_lvl_r && !edge_prev_r;
  assign ext_fall = !ext_lvl_r && edge_prev_r;
  assign ext_edge = option_r.source_edge_select ? ext_fall : ext_rise; // [RULE4]
  assign samp_rise = samp_r && !samp_prev_r;
  assign samp_fall = !samp_r && samp_prev_r;

  assign to_timer = !option_r.prescaler_assign; // [RULE12]
  // timer rate 2^(rate+1), watchdog rate 2^rate
  assign rate_mask = 8'((9'h002 << option_r.prescale_rate) - 9'h001);
  assign wdt_mask = rate_mask >> 1; // [RULE13]
  assign presc_full = (presc_r & rate_mask) == rate_mask;
  assign presc_bit = presc_r[option_r.prescale_rate]; // [RULE13]

  // level fed to the phase sampler in counter mode
  always_comb begin
    if (to_timer) begin
      feed_lvl = presc_bit; // [RULE11]
    end else begin
      feed_lvl = ext_lvl_r; // [RULE9]
    end
  end

  // count increment source
  always_comb begin
    presc_step = 1'b0;
    inc = 1'b0;
    if (!option_r.clock_source_select) begin
      if (to_timer) begin
        presc_step = cycle_tick;
        inc = cycle_tick && presc_full;
      end else begin
        inc = cycle_tick; // [RULE1]
      end
    end else begin
      presc_step = to_timer && ext_edge;
      if (to_timer || !option_r.source_edge_select) begin
        inc = samp_rise; // [RULE3]
      end else begin
        inc = samp_fall; // [RULE4]
      end
    end
    if (!option_r.prescaler_assign) begin
      presc_step = presc_step && (hold_r == HOLD_NONE);
    end else begin
      presc_step = wdt_tick_i;
    end
    if ((hold_r != HOLD_NONE) || sleep_i) begin
      inc = 1'b0; // [RULE2] [RULE8]
    end
  end

  assign ovf = inc && (count_r == COUNT_MAX); // [RULE5]

  // ==========================================================================
  // next-state logic
  always_comb begin
    phase_nxt = phase_r;
    req_nxt = req_r;
    option_nxt = option_r;
    count_nxt = count_r;
    presc_nxt = presc_r;
    hold_nxt = hold_r;
    flag_nxt = flag_r;
    ovf_en_nxt = ovf_en_r;
    rdata_nxt = rdata_r;
    ext_lvl_nxt = ext_lvl_r;
    edge_prev_nxt = ext_lvl_r;
    samp_nxt = samp_r;
    samp_prev_nxt = samp_r;
    wdt_out_nxt = 1'b0;

    // phases stand still in sleep; the synchroniser and edge detectors still follow the pin
    if (!sleep_i) begin
      case (phase_r)
        PH_ONE: phase_nxt = PH_TWO;
        PH_TWO: phase_nxt = PH_THREE;
        PH_THREE: phase_nxt = PH_FOUR;
        PH_FOUR: phase_nxt = PH_ONE;
        default: phase_nxt = PH_ONE;
      endcase
    end

    // a pin change counts once two synchroniser stages agree
    if (sync2_r == sync3_r) begin
      ext_lvl_nxt = sync3_r;
    end

    if (sample_tick && !sleep_i) begin
      samp_nxt = feed_lvl; // [RULE10]
    end

    // prescaler
    if (presc_step && !(sleep_i && to_timer)) begin
      presc_nxt = presc_r + 8'h01; // [RULE11]
    end
    if (option_r.prescaler_assign && wdt_tick_i) begin
      wdt_out_nxt = (presc_r & wdt_mask) == wdt_mask; // [RULE12]
    end

    // write hold counts down on instruction cycle boundaries
    if (cycle_tick && (hold_r != HOLD_NONE) && !sleep_i) begin
      hold_nxt = hold_r - HOLD_STEP; // [RULE2]
    end

    if (inc) begin
      count_nxt = count_r + 8'h01; // [RULE1]
    end

    // set wins over a clear in the same cycle
    if (wr_intctl && !wdata8[OVF_FLAG_BIT]) begin
      flag_nxt = 1'b0; // [RULE7]
    end
    if (wr_clear && wdata8[OVF_FLAG_BIT]) begin
      flag_nxt = 1'b0; // [RULE7]
    end
    if (ovf) begin
      flag_nxt = 1'b1; // [RULE5]
    end

    if (wr_intctl) begin
      ovf_en_nxt = wdata8[OVF_EN_BIT];
    end
    if (wr_enable) begin
      ovf_en_nxt = wdata8[OVF_FLAG_BIT];
    end
    if (wr_option) begin
      option_nxt = option_t'(wdata8);
    end
    if (wr_count) begin
      count_nxt = wdata8; // [RULE14]
      hold_nxt = WRITE_HOLD; // [RULE2]
      if (to_timer) begin
        presc_nxt = PRESC_RST;
      end
    end

    // address phase capture and read data
    req_nxt.sel = addr_ok;
    req_nxt.wr = hwrite_i;
    req_nxt.addr = haddr_i[7:0];
    if (addr_ok && !hwrite_i) begin
      rdata_nxt = 32'h0000_0000;
      if (haddr_i[31:8] == 24'h00_0000) begin
        case (haddr_i[7:0])
          OFF_COUNT: rdata_nxt[7:0] = count_nxt; // [RULE14]
          OFF_OPTION: rdata_nxt[7:0] = option_nxt;
          OFF_INTCTL: begin
            rdata_nxt[OVF_EN_BIT] = ovf_en_nxt;
            rdata_nxt[OVF_FLAG_BIT] = flag_nxt; // [RULE7]
          end
          OFF_STATUS: rdata_nxt[OVF_FLAG_BIT] = flag_nxt;
          OFF_ENABLE: rdata_nxt[OVF_FLAG_BIT] = ovf_en_nxt;
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (addr_ok && (haddr_i[31:8] != 24'h00_0000)) begin
      req_nxt.sel = 1'b0;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clock_i) begin
    sync1_r <= external_count_input_i;
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
    if (rst_i) begin
      phase_r <= PH_ONE;
      req_r <= '0;
      option_r <= option_t'(OPTION_RST);
      count_r <= COUNT_RST;
      presc_r <= PRESC_RST;
      hold_r <= HOLD_NONE;
      flag_r <= 1'b0;
      ovf_en_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      ext_lvl_r <= 1'b0;
      edge_prev_r <= 1'b0;
      samp_r <= 1'b0;
      samp_prev_r <= 1'b0;
      wdt_out_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      req_r <= req_nxt;
      option_r <= option_nxt;
      count_r <= count_nxt;
      presc_r <= presc_nxt;
      hold_r <= hold_nxt;
      flag_r <= flag_nxt;
      ovf_en_r <= ovf_en_nxt;
      rdata_r <= rdata_nxt;
      ext_lvl_r <= ext_lvl_nxt;
      edge_prev_r <= edge_prev_nxt;
      samp_r <= samp_nxt;
      samp_prev_r <= samp_prev_nxt;
      wdt_out_r <= wdt_out_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign hrdata_o = rdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign wdt_tick_o = wdt_out_r;
  assign irq_o = flag_r && ovf_en_r; // [RULE6]

endmodule : eight_bit_timer_counter

// ==== rtl/timer_counter_pkg.sv ====
// package of offsets, fields, reset values and types for the 8-bit timer/counter
package timer_counter_pkg;

  // ==========================================================================
  // bus map (byte addresses)
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_OPTION = 8'h04;
  localparam logic [7:0] OFF_INTCTL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_CLEAR = 8'h10;
  localparam logic [7:0] OFF_ENABLE = 8'h14;

  // ==========================================================================
  // option register fields
  localparam int CSS_BIT = 5;
  localparam int SES_BIT = 4;
  localparam int PSA_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam logic [7:0] OPTION_RST = 8'hFF;

  // ==========================================================================
  // interrupt fields (status, clear and enable use bit 2; control holds the enable at bit 5 and the flag at bit 2)
  localparam int OVF_EN_BIT = 5;
  localparam int OVF_FLAG_BIT = 2;

  // ==========================================================================
  // counting and bus constants
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [1:0] WRITE_HOLD = 2'h2;
  localparam logic [1:0] HOLD_NONE = 2'h0;
  localparam logic [1:0] HOLD_STEP = 2'h1;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} phase_t;

  typedef struct packed {
    logic spare7;
    logic spare6;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_rate;
  } option_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [7:0] addr;
  } ahb_req_t;

endpackage : timer_counter_pkg

// ==== tb/ext_pulse_src.sv ====
// pulse source standing on the external count pin
`timescale 1ns/10ps
// ==========
// pulse source
module ext_pulse_src (
  // control
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] pulses_i,
  // pin
  output logic pin_o
);
  logic [7:0] left_r;
  logic [3:0] ph_r;
  // each level lasts two instruction cycles, so both samplers see it
  assign pin_o = (left_r != 8'h00) & ph_r[3];
  always_ff @(posedge clock_i) begin
    if (rst_i | start_i) begin
      left_r <= rst_i ? 8'h00 : pulses_i;
      ph_r <= 4'h0;
    end else if (left_r != 8'h00) begin
      ph_r <= ph_r + 4'h1;
      if (ph_r == 4'hF) begin
        left_r <= left_r - 8'h01;
      end
    end
  end
endmodule : ext_pulse_src

// ==== tb/tc_chk_checker.sv ====
// bound assertions on the timer/counter ports
`timescale 1ns/10ps
// ==========
// checker
module tc_chk (
  // clock, reset, bus
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  // outputs and system
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic sleep_i,
  input wire logic wdt_tick_i,
  input wire logic wdt_tick_o,
  input wire logic irq_o
);
  import timer_counter_pkg::*;
  logic take;
  logic wdp_r;
  logic rdp_r;
  logic [7:0] wa_r;
  logic [7:0] cw_r;
  logic [3:0] age_r;
  assign take = hsel_i & htrans_i[1] & hready_i & (haddr_i[31:8] == 24'h000000);
  // age since the last count write, saturating
  always_ff @(posedge clock_i) begin
    wdp_r <= ~rst_i & take & hwrite_i;
    rdp_r <= ~rst_i & take & ~hwrite_i & (haddr_i[7:0] == OFF_COUNT);
    wa_r <= haddr_i[7:0];
    if (rst_i) begin
      age_r <= 4'hF;
    end else if (wdp_r && wa_r == OFF_COUNT) begin
      age_r <= 4'h0;
      cw_r <= hwdata_i[7:0];
    end else if (age_r != 4'hF) begin
      age_r <= age_r + 4'h1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready okay");
  a_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !wdt_tick_o)
    else $error("outputs active after reset");
  a_wdt_cause: assert property (wdt_tick_o |-> $past(wdt_tick_i))
    else $error("watchdog tick without input tick");
  a_irq_mask: assert property (wdp_r && (wa_r == OFF_INTCTL && !hwdata_i[OVF_EN_BIT]
    || wa_r == OFF_ENABLE && !hwdata_i[OVF_FLAG_BIT]) |=> !irq_o)
    else $error("irq not masked");
  a_flag_clear: assert property (wdp_r && sleep_i && $past(sleep_i)
    && wa_r == OFF_CLEAR && hwdata_i[OVF_FLAG_BIT] |=> !irq_o)
    else $error("flag not cleared");
  a_sleep_hold: assert property ($past(sleep_i) && $past(sleep_i, 2) && !$past(wdp_r)
    |-> $stable(irq_o))
    else $error("irq moved in sleep");
  a_unmapped_zero: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i
    && haddr_i[31:8] != 24'h000000 |=> hrdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_write_hold: assert property (rdp_r && age_r < 4'h4 |-> hrdata_o[7:0] == cw_r)
    else $error("count moved during hold");
  c_irq: cover property ($rose(irq_o));
  c_wdt: cover property (wdt_tick_o);
  c_hold: cover property (rdp_r && age_r < 4'h4);
endmodule : tc_chk
bind eight_bit_timer_counter tc_chk u_chk (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .sleep_i(sleep_i), .wdt_tick_i(wdt_tick_i), .wdt_tick_o(wdt_tick_o), .irq_o(irq_o));

// ==== tb/eight_bit_timer_counter_tb.sv ====
// self-checking bench for the timer/counter
`timescale 1ns/10ps
// ==========
// bench
module eight_bit_timer_counter_tb;
  import timer_counter_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata, rd_data;
  logic hready, hresp, irq, pin, wdt_out;
  logic sleep = 1'b0;
  logic wdt_in = 1'b0;
  logic src_go = 1'b0;
  logic [7:0] src_n = 8'h00;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int wdt_seen = 0;
  int i;
  always #50 clock_i = ~clock_i;
  eight_bit_timer_counter u_dut (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .external_count_input_i(pin), .sleep_i(sleep), .wdt_tick_i(wdt_in), .wdt_tick_o(wdt_out),
    .irq_o(irq));
  ext_pulse_src u_src (.clock_i(clock_i), .rst_i(rst_i), .start_i(src_go), .pulses_i(src_n),
    .pin_o(pin));
  task tally_and_finish;
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock_i); while (hready !== 1'b1);
    rd_data = hrdata;
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, {24'h000000, a}, 32'h00000000);
    chk(rd_data, e);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h000000, a}, d);
  endtask : wr
  task irq_is(input logic e);
    @(negedge clock_i);
    chk({31'h00000000, irq}, {31'h00000000, e});
  endtask : irq_is
  task pulses(input logic [7:0] n);
    src_n <= n;
    src_go <= 1'b1;
    @(posedge clock_i);
    src_go <= 1'b0;
    repeat (16 * n + 16) @(posedge clock_i);
  endtask : pulses
  always @(posedge clock_i) begin
    cyc++;
    if (wdt_out === 1'b1) wdt_seen++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(OFF_OPTION, 32'h000000FF);
    rd(OFF_COUNT, 32'h00000000);
    bus(1'b0, 32'h00000100, 32'h00000000);
    chk(rd_data, 32'h00000000);
    wr(OFF_OPTION, 32'h0000000A);
    for (i = 0; i < 8; i++) begin
      @(posedge clock_i);
      wdt_in <= 1'b1;
      @(posedge clock_i);
      wdt_in <= 1'b0;
    end
    repeat (3) @(posedge clock_i);
    chk(wdt_seen, 32'h00000002);
    wr(OFF_OPTION, 32'h00000008);
    wr(OFF_INTCTL, 32'h00000020);
    wr(OFF_COUNT, 32'h000000FF);
    rd(OFF_COUNT, 32'h000000FF);
    repeat (4) @(negedge clock_i);
    irq_is(1'b0);
    for (i = 0; i < 12 && irq !== 1'b1; i++) @(negedge clock_i);
    chk({31'h00000000, irq}, 32'h00000001);
    rd(OFF_COUNT, 32'h00000000);
    sleep <= 1'b1;
    wr(OFF_COUNT, 32'h00000080);
    repeat (40) @(posedge clock_i);
    rd(OFF_COUNT, 32'h00000080);
    wr(OFF_INTCTL, 32'h00000004);
    irq_is(1'b0);
    rd(OFF_STATUS, 32'h00000004);
    wr(OFF_ENABLE, 32'h00000004);
    irq_is(1'b1);
    wr(OFF_CLEAR, 32'h00000004);
    irq_is(1'b0);
    sleep <= 1'b0;
    wr(OFF_OPTION, 32'h00000028);
    wr(OFF_COUNT, 32'h00000000);
    pulses(8'h05);
    rd(OFF_COUNT, 32'h00000005);
    wr(OFF_OPTION, 32'h00000038);
    pulses(8'h03);
    rd(OFF_COUNT, 32'h00000008);
    wr(OFF_OPTION, 32'h00000021);
    wr(OFF_COUNT, 32'h00000000);
    pulses(8'h08);
    rd(OFF_COUNT, 32'h00000002);
    tally_and_finish;
  end
endmodule : eight_bit_timer_counter_tb
